// ---- hdl/dip_point_map.sv ----
// Point map of a sixteen-point discrete indicator loop: coils and packed words.
// Assumes requests come from same-clock logic as one-cycle strobes; pins are async.
`default_nettype none
module dip_point_map
    import dip_pkg::*;
#(
    parameter int LOOP_NUM = 1,
    parameter logic [15:0] BASE_CHAN = 16'h0000
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic scanTick,
    input wire logic [15:0] pinDiscIn,
    input wire logic [1:0] pinPanelBtn,
    input wire logic [1:0] btnSustained,
    input wire logic reqValid,
    input wire logic reqWord,
    input wire logic reqWrite,
    input wire logic [15:0] reqAddr,
    input wire logic [7:0] reqParam,
    input wire logic [15:0] reqWdata,
    output logic rspValid,
    output logic rspErr,
    output logic [15:0] rspData,
    output logic [15:0] pointOutput,
    output logic [15:0] pointAuto,
    output logic [1:0] buttonSwitch
);
    localparam logic [15:0] LOOP_IDX = 16'(LOOP_NUM - 1);
    localparam logic [15:0] COIL_OFS = 16'(LOOP_IDX * DIP_COIL_LOOP_STRIDE);
    localparam logic [15:0] BTN_OFS = 16'(LOOP_IDX * DIP_COIL_BTN_STRIDE);
    localparam logic [15:0] IN_COIL = 16'(DIP_COIL_IN_BASE + COIL_OFS);
    localparam logic [15:0] STAT_COIL = 16'(DIP_COIL_STAT_BASE + COIL_OFS);
    localparam logic [15:0] OUT_COIL = 16'(DIP_COIL_OUT_BASE + COIL_OFS);
    localparam logic [15:0] BTN_COIL = 16'(DIP_COIL_BTN_BASE + BTN_OFS);

    logic [15:0] discSync;
    logic [1:0] panelSync;
    logic [15:0] inputVal_ff;
    logic [15:0] status_ff;
    logic [15:0] output_ff;
    logic [1:0] panelPrev_ff;
    logic rspValid_ff;
    logic rspErr_ff;
    logic [15:0] rspData_ff;
    logic [1:0] btnState;

    logic [15:0] nxt_status;
    logic [15:0] nxt_output;
    logic [1:0] simPress;
    logic [1:0] press;
    logic [1:0] panelEdge;
    logic [15:0] nxt_rdata;
    logic nxt_err;
    logic [6:0] coilDec;
    dip_region_t coilRgn;
    logic [3:0] coilIdx;
    logic [15:0] wordSel;

    // Span test in 17 bits so a high loop number cannot wrap the upper bound
    function automatic logic dip_in_span(input logic [15:0] coil, input logic [15:0] base,
                                         input logic [15:0] span);
        return (coil >= base) && (17'(coil) < 17'(base) + 17'(span));
    endfunction

    // Region and bit index of a coil number; shared by reads and writes
    function automatic logic [6:0] dip_coil_decode(input logic [15:0] coil);
        logic [15:0] ofs;
        ofs = 16'h0000;
        if (dip_in_span(coil, IN_COIL, 16'h0010)) begin
            ofs = 16'(coil - IN_COIL);
            return {DIP_RGN_INPUT, ofs[3:0]};
        end else if (dip_in_span(coil, STAT_COIL, 16'h0010)) begin
            ofs = 16'(coil - STAT_COIL);
            return {DIP_RGN_STATUS, ofs[3:0]};
        end else if (dip_in_span(coil, OUT_COIL, 16'h0010)) begin
            ofs = 16'(coil - OUT_COIL);
            return {DIP_RGN_OUTPUT, ofs[3:0]};
        end else if (dip_in_span(coil, BTN_COIL, DIP_COIL_BTN_SPAN)) begin
            ofs = 16'(coil - BTN_COIL);
            if (ofs < DIP_BTN_COUNT) begin
                return {DIP_RGN_BUTTON, ofs[3:0]};
            end
            return {DIP_RGN_SPARE, ofs[3:0]};
        end
        return {DIP_RGN_NONE, 4'h0};
    endfunction

    // One-hot word select by channel offset; zero if not a mapped word
    function automatic logic [15:0] dip_word_decode(input logic [15:0] chan,
                                                    input logic [7:0] param);
        logic [15:0] sel;
        sel = 16'h0000;
        if (param == DIP_WORD_PARAM && chan >= BASE_CHAN) begin
            case (16'(chan - BASE_CHAN))
                DIP_CH_INPUT: sel = 16'h0001;
                DIP_CH_STATUS: sel = 16'h0002;
                DIP_CH_OUTPUT: sel = 16'h0004;
                DIP_CH_BUTTON: sel = 16'h0008;
                default: sel = 16'h0000;
            endcase
        end
        return sel;
    endfunction

    dip_sync #(
        .WIDTH(16)
    ) u_disc_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .pinIn(pinDiscIn),
        .syncOut(discSync)
    );

    dip_sync #(
        .WIDTH(2)
    ) u_panel_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .pinIn(pinPanelBtn),
        .syncOut(panelSync)
    );

    // Region field is cast back to its enum type; the index is the low nibble
    always_comb begin
        coilDec = dip_coil_decode(reqAddr);
        coilRgn = dip_region_t'(coilDec[6:4]);
        coilIdx = coilDec[3:0];
        wordSel = dip_word_decode(reqAddr, reqParam);
    end

    // Inputs are the values seen at the last scan, as the controller would report
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            inputVal_ff <= DIP_INPUT_RST;
        end else if (ce && scanTick) begin
            inputVal_ff <= discSync;
        end
    end

    // Writes act only in the single request cycle, so a held value never re-fires
    always_comb begin
        nxt_status = status_ff;
        nxt_output = output_ff;
        if (reqValid && reqWrite) begin
            if (reqWord) begin
                if (wordSel[1]) begin
                    nxt_status = status_ff ^ reqWdata;
                end
                if (wordSel[2]) begin
                    nxt_output = reqWdata;
                end
            end else begin
                case (coilRgn)
                    DIP_RGN_STATUS: begin
                        if (reqWdata[0]) begin
                            nxt_status[coilIdx] = ~status_ff[coilIdx];
                        end
                    end
                    DIP_RGN_OUTPUT: begin
                        nxt_output[coilIdx] = reqWdata[0];
                    end
                    // Input and spare coils take writes with no effect
                    default: begin
                        nxt_output = output_ff;
                    end
                endcase
            end
        end
    end

    // Simulated presses last only the request cycle; the buttons see a pulse
    always_comb begin
        simPress = 2'b00;
        if (reqValid && reqWrite) begin
            if (reqWord) begin
                if (wordSel[3]) begin
                    simPress = reqWdata[1:0];
                end
            end else if (coilRgn == DIP_RGN_BUTTON) begin
                simPress[coilIdx[0]] = reqWdata[0];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            status_ff <= DIP_STATUS_RST;
        end else if (ce) begin
            status_ff <= nxt_status;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            output_ff <= DIP_OUTPUT_RST;
        end else if (ce) begin
            output_ff <= nxt_output;
        end
    end

    // Panel presses count on the rising edge so a held button fires once
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            panelPrev_ff <= 2'b00;
        end else if (ce) begin
            panelPrev_ff <= panelSync;
        end
    end

    assign panelEdge = panelSync & ~panelPrev_ff;
    assign press = simPress | panelEdge;

    for (genvar b = 0; b < 2; b++) begin : g_btn
        dip_button u_btn (
            .mclk(mclk),
            .rst_n(rst_n),
            .ce(ce),
            .sustained(btnSustained[b]),
            .press(press[b]),
            .scanTick(scanTick),
            .switchOn(btnState[b])
        );
    end

    // Read data; writes also return the value as it stood before the write
    always_comb begin
        nxt_rdata = 16'h0000;
        nxt_err = 1'b0;
        if (reqWord) begin
            case (wordSel)
                16'h0001: nxt_rdata = inputVal_ff;
                16'h0002: nxt_rdata = status_ff;
                16'h0004: nxt_rdata = output_ff;
                16'h0008: nxt_rdata = {14'h0000, btnState};
                default: nxt_err = 1'b1;
            endcase
        end else begin
            case (coilRgn)
                DIP_RGN_INPUT: nxt_rdata = {15'h0000, inputVal_ff[coilIdx]};
                DIP_RGN_STATUS: nxt_rdata = {15'h0000, status_ff[coilIdx]};
                DIP_RGN_OUTPUT: nxt_rdata = {15'h0000, output_ff[coilIdx]};
                DIP_RGN_BUTTON: nxt_rdata = {15'h0000, btnState[coilIdx[0]]};
                DIP_RGN_SPARE: nxt_rdata = 16'h0000;
                default: nxt_err = 1'b1;
            endcase
        end
    end

    // Answer strobe follows every taken request by one cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rspValid_ff <= 1'b0;
        end else if (ce) begin
            rspValid_ff <= reqValid;
        end
    end

    // Error and data stand until the next taken request
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rspErr_ff <= 1'b0;
        end else if (ce && reqValid) begin
            rspErr_ff <= nxt_err;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rspData_ff <= 16'h0000;
        end else if (ce && reqValid) begin
            rspData_ff <= nxt_rdata;
        end
    end

    assign rspValid = rspValid_ff;
    assign rspErr = rspErr_ff;
    assign rspData = rspData_ff;
    assign pointOutput = output_ff;
    assign pointAuto = status_ff;
    assign buttonSwitch = btnState;
endmodule
`default_nettype wire

// ---- common/dip_pkg.sv ----
// Constants for the discrete indicator point map.
// Assumes one loop instance per block; loop number and base channel are parameters.
`default_nettype none
package dip_pkg;
    localparam int DIP_POINTS = 16;
    // Coil numbers for loop 1; each further loop adds the stride
    localparam logic [15:0] DIP_COIL_IN_BASE = 16'h0128;      // 296
    localparam logic [15:0] DIP_COIL_STAT_BASE = 16'h0138;    // 312
    localparam logic [15:0] DIP_COIL_OUT_BASE = 16'h0148;     // 328
    localparam logic [15:0] DIP_COIL_LOOP_STRIDE = 16'h0030;  // 48
    localparam logic [15:0] DIP_COIL_BTN_BASE = 16'h21FD;     // 8701
    localparam logic [15:0] DIP_COIL_BTN_STRIDE = 16'h0010;   // 16
    localparam logic [15:0] DIP_COIL_BTN_SPAN = 16'h0010;     // 2 buttons + 14 spares
    localparam logic [15:0] DIP_BTN_COUNT = 16'h0002;
    // Channel offsets from the loop base channel; parameter number of all words
    localparam logic [15:0] DIP_CH_INPUT = 16'h0000;
    localparam logic [15:0] DIP_CH_STATUS = 16'h0001;
    localparam logic [15:0] DIP_CH_OUTPUT = 16'h0002;
    localparam logic [15:0] DIP_CH_BUTTON = 16'h0003;
    localparam logic [7:0] DIP_WORD_PARAM = 8'h01;
    // Values after reset
    localparam logic [15:0] DIP_STATUS_RST = 16'hFFFF;   // All points in auto
    localparam logic [15:0] DIP_OUTPUT_RST = 16'h0000;
    localparam logic [15:0] DIP_INPUT_RST = 16'h0000;

    typedef enum logic [2:0] {
        DIP_RGN_NONE,
        DIP_RGN_INPUT,
        DIP_RGN_STATUS,
        DIP_RGN_OUTPUT,
        DIP_RGN_BUTTON,
        DIP_RGN_SPARE
    } dip_region_t;
endpackage
`default_nettype wire

// ---- hdl/dip_sync.sv ----
// Two-stage synchroniser for a group of pin inputs.
// Assumes the pins are asynchronous to mclk; only stage two is read outside.
`default_nettype none
module dip_sync #(
    parameter int WIDTH = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else if (ce) begin
            meta_ff <= pinIn;
            sync_ff <= meta_ff;
        end
    end

    assign syncOut = sync_ff;
endmodule
`default_nettype wire

// ---- hdl/dip_button.sv ----
// One pushbutton switch: sustained or momentary action.
// Assumes press is a one-cycle pulse and scanTick marks controller scan starts.
`default_nettype none
module dip_button (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic sustained,
    input wire logic press,
    input wire logic scanTick,
    output logic switchOn
);
    logic switch_ff;
    logic pending_ff;

    // Momentary press waits for the next scan so the closure spans one whole scan
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pending_ff <= 1'b0;
        end else if (ce) begin
            if (sustained) begin
                pending_ff <= 1'b0;
            end else if (press) begin
                pending_ff <= 1'b1;
            end else if (scanTick) begin
                pending_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            switch_ff <= 1'b0;
        end else if (ce) begin
            if (sustained) begin
                if (press) begin
                    switch_ff <= ~switch_ff;
                end
            end else if (scanTick) begin
                switch_ff <= pending_ff;
            end
        end
    end

    assign switchOn = switch_ff;
endmodule
`default_nettype wire

// ---- testbench/dip_point_map_assertions.sv ----
// Checker of the point map: answer timing, toggles, words and buttons.
// Assumes it is bound to dip_point_map and sees only that module's ports.
`default_nettype none
module dip_point_map_assertions
    import dip_pkg::*;
#(
    parameter int LOOP_NUM = 1,
    parameter logic [15:0] BASE_CHAN = 16'h0000
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic scanTick,
    input wire logic [1:0] btnSustained,
    input wire logic reqValid,
    input wire logic reqWord,
    input wire logic reqWrite,
    input wire logic [15:0] reqAddr,
    input wire logic [7:0] reqParam,
    input wire logic [15:0] reqWdata,
    input wire logic rspValid,
    input wire logic rspErr,
    input wire logic [15:0] rspData,
    input wire logic [15:0] pointOutput,
    input wire logic [15:0] pointAuto,
    input wire logic [1:0] buttonSwitch
);
    timeunit 1ns;
    timeprecision 1ps;
    logic take;
    logic wordOk;
    logic [15:0] ch;
    logic [15:0] statCoil;
    assign take = ce && reqValid;
    assign wordOk = take && reqWord && reqParam == DIP_WORD_PARAM;
    assign ch = reqAddr - BASE_CHAN;
    assign statCoil = DIP_COIL_STAT_BASE + DIP_COIL_LOOP_STRIDE * 16'(LOOP_NUM - 1);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_answer_next: assert property (take |=> rspValid)
        else $error("no answer after a request");
    a_single_answer: assert property (ce && !reqValid |=> !rspValid)
        else $error("answer without a request");
    a_auto_quiet: assert property (!(take && reqWrite) |=> $stable(pointAuto))
        else $error("switch status moved without a write");
    a_status_flip: assert property (take && !reqWord && reqWrite && reqWdata[0]
        && reqAddr == statCoil |=> pointAuto[0] != $past(pointAuto[0]))
        else $error("status coil write did not toggle");
    a_status_xor: assert property (wordOk && reqWrite && ch == DIP_CH_STATUS
        |=> pointAuto == ($past(pointAuto) ^ $past(reqWdata)))
        else $error("status word write is not a toggle");
    a_output_word: assert property (wordOk && reqWrite && ch == DIP_CH_OUTPUT
        |=> pointOutput == $past(reqWdata))
        else $error("output word not stored");
    a_input_ro: assert property (wordOk && reqWrite && ch == DIP_CH_INPUT
        |=> !rspErr && $stable(pointOutput) && $stable(pointAuto))
        else $error("input word write had an effect");
    a_bad_param: assert property (take && reqWord && reqParam != DIP_WORD_PARAM
        |=> rspErr && rspData == 16'h0000)
        else $error("wrong parameter not refused");
    a_button_read: assert property (wordOk && !reqWrite && ch == DIP_CH_BUTTON
        |=> rspData == {14'h0000, $past(buttonSwitch)})
        else $error("button word read is not switch state");
    a_sustain_flip: assert property (wordOk && reqWrite && ch == DIP_CH_BUTTON
        && reqWdata[0] && btnSustained[0] |=> buttonSwitch[0] != $past(buttonSwitch[0]))
        else $error("sustained press did not flip");
    a_momentary_scan: assert property (ce && scanTick && buttonSwitch[1]
        && !btnSustained[1] |=> !buttonSwitch[1])
        else $error("momentary switch held past one scan");
endmodule

bind dip_point_map dip_point_map_assertions
    #(.LOOP_NUM(LOOP_NUM), .BASE_CHAN(BASE_CHAN)) chk (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .scanTick(scanTick), .btnSustained(btnSustained),
    .reqValid(reqValid), .reqWord(reqWord), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqParam(reqParam), .reqWdata(reqWdata), .rspValid(rspValid), .rspErr(rspErr),
    .rspData(rspData), .pointOutput(pointOutput), .pointAuto(pointAuto),
    .buttonSwitch(buttonSwitch));
`default_nettype wire

// ---- testbench/dip_master_model.sv ----
// Network master model: single coil and word requests, one at a time.
// Assumes a one-cycle strobe and a registered answer on the same clock.
`default_nettype none
module dip_master_model (
    input wire logic mclk,
    input wire logic rspValid,
    input wire logic rspErr,
    input wire logic [15:0] rspData,
    output logic reqValid,
    output logic reqWord,
    output logic reqWrite,
    output logic [15:0] reqAddr,
    output logic [7:0] reqParam,
    output logic [15:0] reqWdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reqValid = 1'b0;
        reqWord = 1'b0;
        reqWrite = 1'b0;
        reqAddr = 16'hFFFF;
        reqParam = 8'hFF;
        reqWdata = 16'hFFFF;
    end
    task automatic access(input logic w, input logic wr, input logic [15:0] a,
        input logic [7:0] p, input logic [15:0] d, output logic [15:0] data,
        output logic err, output logic ok);
        ok = 1'b0;
        @(posedge mclk);
        reqValid <= 1'b1;
        reqWord <= w;
        reqWrite <= wr;
        reqAddr <= a;
        reqParam <= p;
        reqWdata <= d;
        @(posedge mclk);
        reqValid <= 1'b0;
        // Released lines show no stale value
        reqAddr <= ~a;
        reqParam <= ~p;
        reqWdata <= ~d;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge mclk);
            if (rspValid === 1'b1) begin
                data = rspData;
                err = rspErr;
                ok = 1'b1;
            end
        end
    endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench of the point map: inputs, status, outputs, buttons.
// Assumes loop 1, base channel 0, and the master model on the request port.
`default_nettype none
module testbench
    import dip_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst_n, ce, scanTick, reqValid, reqWord, reqWrite, rspValid, rspErr, er, ok;
    logic [15:0] pinDiscIn, reqAddr, reqWdata, rspData, pointOutput, pointAuto, rd;
    logic [7:0] reqParam;
    logic [1:0] pinPanelBtn, btnSustained, buttonSwitch;
    int n_fail;
    int num_checks;

    dip_point_map DUT (.mclk(mclk), .rst_n(rst_n), .ce(ce), .scanTick(scanTick),
        .pinDiscIn(pinDiscIn), .pinPanelBtn(pinPanelBtn), .btnSustained(btnSustained),
        .reqValid(reqValid), .reqWord(reqWord), .reqWrite(reqWrite), .reqAddr(reqAddr),
        .reqParam(reqParam), .reqWdata(reqWdata), .rspValid(rspValid), .rspErr(rspErr),
        .rspData(rspData), .pointOutput(pointOutput), .pointAuto(pointAuto),
        .buttonSwitch(buttonSwitch));
    dip_master_model M (.mclk(mclk), .rspValid(rspValid), .rspErr(rspErr),
        .rspData(rspData), .reqValid(reqValid), .reqWord(reqWord), .reqWrite(reqWrite),
        .reqAddr(reqAddr), .reqParam(reqParam), .reqWdata(reqWdata));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic check(string nm, logic [15:0] got, logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic results();
        $display("Checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic acc(logic w, logic wr, logic [15:0] a, logic [7:0] p, logic [15:0] d);
        M.access(w, wr, a, p, d, rd, er, ok);
        if (!ok) begin
            n_fail++;
            $display("CHECK FAILED answer expected 1 seen 0");
            results();
        end
    endtask
    task automatic scan();
        @(posedge mclk);
        scanTick <= 1'b1;
        @(posedge mclk);
        scanTick <= 1'b0;
        @(negedge mclk);
    endtask

    task automatic t_inputs();
        @(posedge mclk);
        pinDiscIn <= 16'hA5C3;
        repeat (3) @(posedge mclk);
        scan();
        acc(1'b1, 1'b0, DIP_CH_INPUT, DIP_WORD_PARAM, 16'h0000);
        check("input word", rd, 16'hA5C3);
        for (int k = 0; k < 16; k++) begin
            acc(1'b0, 1'b0, DIP_COIL_IN_BASE + 16'(k), 8'h00, 16'h0000);
            check("input coil", rd, {15'h0000, pinDiscIn[k]});
        end
        acc(1'b1, 1'b1, DIP_CH_INPUT, DIP_WORD_PARAM, 16'h0000);
        check("input write err", {15'h0000, er}, 16'h0000);
        acc(1'b1, 1'b0, DIP_CH_INPUT, 8'h02, 16'h0000);
        check("bad param err", {15'h0000, er}, 16'h0001);
        acc(1'b0, 1'b0, DIP_COIL_IN_BASE - 16'h0001, 8'h00, 16'h0000);
        check("below map err", {15'h0000, er}, 16'h0001);
    endtask

    task automatic t_freeze();
        @(posedge mclk);
        ce <= 1'b0;
        pinDiscIn <= 16'h0F0F;
        repeat (4) @(posedge mclk);
        scan();
        @(posedge mclk);
        ce <= 1'b1;
        acc(1'b1, 1'b0, DIP_CH_INPUT, DIP_WORD_PARAM, 16'h0000);
        check("frozen inputs", rd, 16'hA5C3);
    endtask

    task automatic t_status();
        acc(1'b0, 1'b1, DIP_COIL_STAT_BASE, 8'h00, 16'h0001);
        check("status toggled", pointAuto, 16'hFFFE);
        acc(1'b0, 1'b0, DIP_COIL_STAT_BASE, 8'h00, 16'h0000);
        check("manual reads 0", rd, 16'h0000);
        acc(1'b0, 1'b1, DIP_COIL_STAT_BASE, 8'h00, 16'h0000);
        check("write 0 ignored", pointAuto, 16'hFFFE);
        acc(1'b1, 1'b1, DIP_CH_STATUS, DIP_WORD_PARAM, 16'h0009);
        check("status old value", rd, 16'hFFFE);
        scan();
        scan();
        check("no repeat on scans", pointAuto, 16'hFFF7);
        acc(1'b1, 1'b0, DIP_CH_STATUS, DIP_WORD_PARAM, 16'h0000);
        check("status word", rd, 16'hFFF7);
    endtask

    task automatic t_outputs();
        for (int k = 0; k < 16; k++)
            acc(1'b0, 1'b1, DIP_COIL_OUT_BASE + 16'(k), 8'h00, 16'(k % 2));
        check("output coils", pointOutput, 16'hAAAA);
        acc(1'b1, 1'b0, DIP_CH_OUTPUT, DIP_WORD_PARAM, 16'h0000);
        check("output word", rd, 16'hAAAA);
        acc(1'b1, 1'b1, DIP_CH_OUTPUT, DIP_WORD_PARAM, 16'h1234);
        acc(1'b0, 1'b0, DIP_COIL_OUT_BASE + 16'h0002, 8'h00, 16'h0000);
        check("output coil read", rd, 16'h0001);
    endtask

    task automatic t_buttons();
        acc(1'b1, 1'b1, DIP_CH_BUTTON, DIP_WORD_PARAM, 16'h0001);
        @(negedge mclk);
        check("sustained on", {14'h0000, buttonSwitch}, 16'h0001);
        scan();
        acc(1'b1, 1'b0, DIP_CH_BUTTON, DIP_WORD_PARAM, 16'h0000);
        check("button word", rd, 16'h0001);
        acc(1'b0, 1'b1, DIP_COIL_BTN_BASE + 16'h0001, 8'h00, 16'h0001);
        @(negedge mclk);
        check("momentary waits", {14'h0000, buttonSwitch}, 16'h0001);
        scan();
        check("momentary closed", {14'h0000, buttonSwitch}, 16'h0003);
        acc(1'b0, 1'b0, DIP_COIL_BTN_BASE + 16'h0001, 8'h00, 16'h0000);
        check("button coil", rd, 16'h0001);
        scan();
        check("momentary open", {14'h0000, buttonSwitch}, 16'h0001);
        scan();
        check("no second close", {14'h0000, buttonSwitch}, 16'h0001);
        acc(1'b0, 1'b0, DIP_COIL_BTN_BASE + 16'h0002, 8'h00, 16'h0000);
        check("spare coil", {rd[14:0], er}, 16'h0000);
        acc(1'b0, 1'b0, DIP_COIL_BTN_BASE + DIP_COIL_BTN_SPAN, 8'h00, 16'h0000);
        check("past spares err", {15'h0000, er}, 16'h0001);
        @(posedge mclk);
        pinPanelBtn <= 2'b01;
        repeat (5) @(posedge mclk);
        pinPanelBtn <= 2'b00;
        repeat (5) @(negedge mclk);
        check("panel press", {14'h0000, buttonSwitch}, 16'h0000);
    endtask

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        scanTick = 1'b0;
        pinDiscIn = 16'h0000;
        pinPanelBtn = 2'b00;
        btnSustained = 2'b01;
        n_fail = 0;
        num_checks = 0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        check("auto after reset", pointAuto, DIP_STATUS_RST);
        check("output after reset", pointOutput, DIP_OUTPUT_RST);
        t_inputs();
        t_freeze();
        t_status();
        t_outputs();
        t_buttons();
        results();
    end
endmodule
`default_nettype wire
